// [logic/mem_mgmt_fault_status_low.sv]
// Lower memory management fault status flags with fault address and stacking control
//
// Overview of operation
// - A failed context restore on exception return sets the unstack flag in bit 3 while the protection unit is on.
// - An unstack fault chains to the handler so the original return frame stays in memory.
// - On an unstack fault the stacked PC keeps its value, the stack pointer takes the reported value, and no new context save is started.
// - An unstack fault never loads the fault address register.
// - Each flag stays set until software writes 1 to its bit, and all flags reset to zero.
// - A load or store that its permissions forbid sets the data flag in bit 1 while the protection unit is on.
// - A data fault stacks the faulting instruction's PC and captures the access address.
// - A fetch from a location that forbids execution sets the instruction flag in bit 0.
// - A fetch from an execute-never region faults whether or not the protection unit is on.
// - An instruction fault stacks the faulting instruction's PC and leaves the address register alone.
// - The address register holds the faulting address whenever its valid flag is set.
`timescale 1ns/10ps
module mem_mgmt_fault_status_low
   import mem_fault_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire mem_fault_pkg::wb_req_t wbReq,
   output mem_fault_pkg::wb_rsp_t wbRsp,
   // Fault reports from the core
   input wire mem_fault_pkg::fault_evt_t faultEvt,
   input wire logic mpuEnable,
   // Handler entry control
   output logic handlerEntry,
   output logic contextSave,
   output logic [31:0] stackedPc,
   output logic [31:0] stackPointer,
   output logic [3:0] statusFlags
);
   import mem_fault_pkg::*;

   // ****************************************
   // Fault classification
   // ****************************************
   fault_kind_t kind;
   logic instrHit;
   logic dataHit;
   logic unstackHit;
   logic [31:0] control;

   always_comb begin
      // Execute-never applies even with the protection unit off; it is a fixed map attribute
      instrHit = faultEvt.fetch && (faultEvt.fetchInExecNever ||
                 (mpuEnable && faultEvt.fetchDenied));
      dataHit = faultEvt.dataAccess && mpuEnable && faultEvt.dataDenied;
      unstackHit = faultEvt.unstack && mpuEnable;
      // Unstack faults take priority: the pipeline is idle during a return
      if (unstackHit) begin
         kind = FAULT_UNSTACK;
      end else if (dataHit) begin
         kind = FAULT_DATA;
      end else if (instrHit) begin
         kind = FAULT_INSTR;
      end else begin
         kind = FAULT_NONE;
      end
   end

   // ****************************************
   // Bus decode
   // ****************************************
   logic access;
   logic wrStrobe;
   logic rdStrobe;
   logic laneZero;
   logic selStatus;
   logic selAddress;
   logic selControl;
   logic selStack;
   logic selPc;
   logic [3:0] clearMask;
   logic clearValid;

   // Taken only while ack is low, so a strobe held through the answer is served once
   always_comb begin
      access = wbReq.cyc && wbReq.stb && !wbRsp.ack;
      wrStrobe = access && wbReq.we;
      rdStrobe = access && !wbReq.we;
      laneZero = wbReq.sel[0];
      selStatus = (wbReq.adr == STATUS_OFFSET);
      selAddress = (wbReq.adr == ADDRESS_OFFSET);
      selControl = (wbReq.adr == CONTROL_OFFSET);
      selStack = (wbReq.adr == SP_OFFSET);
      selPc = (wbReq.adr == PC_OFFSET);
   end

   // Only byte lane 0 carries writable bits
   always_comb begin
      clearMask = 4'h0;
      clearValid = 1'b0;
      if (wrStrobe && selStatus && laneZero) begin
         clearMask = wbReq.dat[3:0];
         clearMask[RESERVED_BIT] = 1'b0;
         clearValid = wbReq.dat[VALID_BIT];
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   logic [3:0] setMask;
   logic [3:0] next_statusFlags;

   // Every hit raises its own flag, even when another fault wins the stacking
   always_comb begin
      setMask = 4'h0;
      setMask[UNSTACK_BIT] = unstackHit;
      setMask[DATA_BIT] = dataHit;
      setMask[INSTR_BIT] = instrHit;
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (i == RESERVED_BIT) begin
            next_statusFlags[i] = 1'b0;
         end else if (setMask[i]) begin
            // A set in the same cycle as a clear wins
            next_statusFlags[i] = 1'b1;
         end else if (clearMask[i]) begin
            next_statusFlags[i] = 1'b0;
         end else begin
            next_statusFlags[i] = statusFlags[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         statusFlags <= FLAGS_RESET;
      end else begin
         statusFlags <= next_statusFlags;
      end
   end

   // ****************************************
   // Fault address
   // ****************************************
   logic [31:0] faultAddress;
   logic [31:0] next_faultAddress;
   logic addressValid;
   logic next_addressValid;

   always_comb begin
      next_faultAddress = faultAddress;
      next_addressValid = addressValid && !clearValid;
      // Only a data fault carries a meaningful address; its valid set beats a clear
      if (kind == FAULT_DATA) begin
         next_faultAddress = faultEvt.addr;
         next_addressValid = 1'b1;
      end else if (kind == FAULT_UNSTACK) begin
         next_faultAddress = faultAddress;
      end else if (kind == FAULT_INSTR) begin
         next_faultAddress = faultAddress;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         faultAddress <= WORD_RESET;
         addressValid <= 1'b0;
      end else begin
         faultAddress <= next_faultAddress;
         addressValid <= next_addressValid;
      end
   end

   // ****************************************
   // Handler entry
   // ****************************************
   logic next_handlerEntry;
   logic next_contextSave;

   always_comb begin
      next_handlerEntry = 1'b0;
      next_contextSave = 1'b0;
      unique case (kind)
         FAULT_UNSTACK: begin
            // Chained entry: the return frame that failed to pop stays in memory
            next_handlerEntry = 1'b1;
            next_contextSave = 1'b0;
         end
         FAULT_DATA: begin
            next_handlerEntry = 1'b1;
            next_contextSave = 1'b1;
         end
         FAULT_INSTR: begin
            next_handlerEntry = 1'b1;
            next_contextSave = 1'b1;
         end
         FAULT_NONE: begin
            next_handlerEntry = 1'b0;
            next_contextSave = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         handlerEntry <= 1'b0;
         contextSave <= 1'b0;
      end else begin
         handlerEntry <= next_handlerEntry;
         contextSave <= next_contextSave;
      end
   end

   // ****************************************
   // Stacked frame
   // ****************************************
   logic [31:0] next_stackedPc;
   logic [31:0] next_stackPointer;

   always_comb begin
      next_stackedPc = stackedPc;
      next_stackPointer = stackPointer;
      unique case (kind)
         FAULT_UNSTACK: begin
            // The stacked PC is kept; the pointer of the failing return is taken from the report unadjusted
            next_stackedPc = stackedPc;
            next_stackPointer = faultEvt.sp;
         end
         FAULT_DATA: begin
            next_stackedPc = faultEvt.pc;
            next_stackPointer = faultEvt.sp;
         end
         FAULT_INSTR: begin
            next_stackedPc = faultEvt.pc;
            next_stackPointer = faultEvt.sp;
         end
         FAULT_NONE: begin
            next_stackedPc = stackedPc;
            next_stackPointer = stackPointer;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stackedPc <= WORD_RESET;
         stackPointer <= WORD_RESET;
      end else begin
         stackedPc <= next_stackedPc;
         stackPointer <= next_stackPointer;
      end
   end

   // ****************************************
   // Control register
   // ****************************************
   logic [31:0] next_control;

   // Only bit 0 is stored; the other bits read zero
   always_comb begin
      next_control = control;
      if (wrStrobe && selControl && laneZero) begin
         next_control = {31'h0, wbReq.dat[EXEC_NEVER_ENABLE_BIT]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         control <= CONTROL_RESET;
      end else begin
         control <= next_control;
      end
   end

   // ****************************************
   // Bus answer
   // ****************************************
   wb_rsp_t next_wbRsp;

   always_comb begin
      next_wbRsp.ack = access;
      next_wbRsp.dat = 32'h0;
      if (rdStrobe) begin
         if (selStatus) begin
            // Reserved bits read as zero, and a flag in bits 0 to 3 set in this cycle already shows; the valid bit shows its registered value
            next_wbRsp.dat = {24'h0, addressValid, 3'h0, next_statusFlags & 4'hb};
         end else if (selAddress) begin
            next_wbRsp.dat = faultAddress;
         end else if (selControl) begin
            next_wbRsp.dat = control;
         end else if (selStack) begin
            next_wbRsp.dat = stackPointer;
         end else if (selPc) begin
            next_wbRsp.dat = stackedPc;
         end else begin
            // Unmapped offsets read zero
            next_wbRsp.dat = 32'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wbRsp <= '0;
      end else begin
         wbRsp <= next_wbRsp;
      end
   end

endmodule : mem_mgmt_fault_status_low

// [logic/mem_fault_pkg.sv]
// Package: offsets, field positions, reset values and carrier types of the memory fault status block
package mem_fault_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] STATUS_OFFSET = 8'h00;
   localparam logic [7:0] ADDRESS_OFFSET = 8'h04;
   localparam logic [7:0] CONTROL_OFFSET = 8'h08;
   localparam logic [7:0] SP_OFFSET = 8'h0c;
   localparam logic [7:0] PC_OFFSET = 8'h10;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int INSTR_BIT = 0;
   localparam int DATA_BIT = 1;
   localparam int RESERVED_BIT = 2;
   localparam int UNSTACK_BIT = 3;
   localparam int VALID_BIT = 7;
   localparam int EXEC_NEVER_ENABLE_BIT = 0;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [31:0] WORD_RESET = 32'h0;
   localparam logic [31:0] CONTROL_RESET = 32'h00000001;

   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // One-cycle fault report from the core pipeline
   typedef struct packed {
      logic fetch;
      logic fetchDenied;
      logic fetchInExecNever;
      logic dataAccess;
      logic dataDenied;
      logic unstack;
      logic [31:0] addr;
      logic [31:0] pc;
      logic [31:0] sp;
   } fault_evt_t;

   typedef enum logic [1:0] {
      FAULT_NONE = 2'b00,
      FAULT_INSTR = 2'b01,
      FAULT_DATA = 2'b10,
      FAULT_UNSTACK = 2'b11
   } fault_kind_t;

endpackage : mem_fault_pkg

// [sim/mem_fault_source.sv]
// Core model: turns a requested fault kind into a one-cycle fault report
`timescale 1ns/10ps
module fault_source (
   // Request from the bench
   input wire logic clk,
   input wire mem_fault_pkg::fault_kind_t kind,
   input wire logic execNever,
   input wire logic [31:0] val,
   // Report to the block
   output mem_fault_pkg::fault_evt_t evt
);
   import mem_fault_pkg::*;
   logic [31:0] junk = 32'h0000a5a5;
   fault_evt_t nextEvt;
   // Idle words toggle so a stale capture cannot pass
   always @(posedge clk) begin
      nextEvt = {6'h0, junk, ~junk, junk};
      if (kind != FAULT_NONE) begin
         nextEvt.addr = val;
         nextEvt.pc = ~val;
         nextEvt.sp = val ^ 32'h0000ff00;
      end
      nextEvt.unstack = kind == FAULT_UNSTACK;
      nextEvt.dataAccess = kind == FAULT_DATA;
      nextEvt.dataDenied = kind == FAULT_DATA;
      nextEvt.fetch = kind == FAULT_INSTR;
      nextEvt.fetchInExecNever = kind == FAULT_INSTR && execNever;
      nextEvt.fetchDenied = kind == FAULT_INSTR && !execNever;
      junk <= ~junk;
      evt <= nextEvt;
   end
endmodule : fault_source

// [sim/mem_fault_checker_assertions.sv]
// Checker: port properties of the memory fault status block
`timescale 1ns/10ps
module mem_fault_checker (
   // Inputs of the block and its bus answer
   input wire logic clk,
   input wire logic rst,
   input wire mem_fault_pkg::wb_req_t wbReq,
   input wire mem_fault_pkg::wb_rsp_t wbRsp,
   input wire mem_fault_pkg::fault_evt_t faultEvt,
   input wire logic mpuEnable,
   // Outputs of the block
   input wire logic handlerEntry,
   input wire logic contextSave,
   input wire logic [31:0] stackedPc,
   input wire logic [31:0] stackPointer,
   input wire logic [3:0] statusFlags
);
   import mem_fault_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic un, da, ins;
   logic [3:0] clr;
   // Priority unstack over data over fetch
   assign un = faultEvt.unstack & mpuEnable;
   assign da = faultEvt.dataAccess & faultEvt.dataDenied & mpuEnable & !un;
   assign ins = faultEvt.fetch & (faultEvt.fetchInExecNever | faultEvt.fetchDenied & mpuEnable) & !un & !da;
   assign clr = wbReq.cyc & wbReq.stb & wbReq.we & wbReq.sel[0] & !wbRsp.ack & wbReq.adr == STATUS_OFFSET
      ? wbReq.dat[3:0] : 4'h0;
   sequence s_chained; handlerEntry && !contextSave; endsequence
   sequence s_saved; handlerEntry && contextSave; endsequence
   a_unstack_flag: assert property (un |=> statusFlags[3])
      else $error("unstack flag missing");
   a_unstack_chain: assert property (un |=> s_chained)
      else $error("unstack entry wrong");
   a_unstack_frame: assert property (un |=> $stable(stackedPc) && stackPointer == $past(faultEvt.sp))
      else $error("unstack frame moved");
   a_data_capture: assert property (da |=> s_saved ##0
      statusFlags[1] && stackedPc == $past(faultEvt.pc)) else $error("data fault wrong");
   a_instr_capture: assert property (ins |=> s_saved ##0
      statusFlags[0] && stackedPc == $past(faultEvt.pc)) else $error("fetch fault wrong");
   a_exec_never_fetch: assert property (faultEvt.fetch && faultEvt.fetchInExecNever |=> statusFlags[0])
      else $error("execute-never fetch ignored");
   a_reserved_zero: assert property (!statusFlags[2])
      else $error("reserved bit set");
   a_flags_sticky: assert property (1'b1 |=> ($past(statusFlags) & ~statusFlags & ~$past(clr)) == 4'h0)
      else $error("flag lost");
   a_reset_clear: assert property (disable iff (1'b0) rst |=> statusFlags == 4'h0 && !handlerEntry)
      else $error("reset left state");
endmodule : mem_fault_checker
bind mem_mgmt_fault_status_low mem_fault_checker u_chk (.clk(clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp),
   .faultEvt(faultEvt), .mpuEnable(mpuEnable), .handlerEntry(handlerEntry), .contextSave(contextSave),
   .stackedPc(stackedPc), .stackPointer(stackPointer), .statusFlags(statusFlags));

// [sim/test_mem_mgmt_fault_status_low.sv]
// Bench: random faults and register traffic against a reference model
`timescale 1ns/10ps
module test_mem_mgmt_fault_status_low;
   import mem_fault_pkg::*;
   logic clk = 0, rst = 1, mpu = 0, execNever = 0, hEntry, cSave;
   logic [31:0] val = 0, sPc, sp, rd, seed = 41444, m, eA = 0, ePc = 0, eSp = 0;
   logic [3:0] flags;
   wb_req_t req = '0;
   wb_rsp_t rsp;
   fault_evt_t evt;
   fault_kind_t kind = FAULT_NONE;
   int failCount = 0, checked = 0, cycles = 0, fl = 0, va = 0;
   mem_mgmt_fault_status_low u_dut (.clk(clk), .rst(rst), .wbReq(req), .wbRsp(rsp), .faultEvt(evt),
      .mpuEnable(mpu), .handlerEntry(hEntry), .contextSave(cSave), .stackedPc(sPc),
      .stackPointer(sp), .statusFlags(flags));
   fault_source u_src (.clk(clk), .kind(kind), .execNever(execNever), .val(val), .evt(evt));
   initial forever #12.5 clk = ~clk;
   // Whole run needs about 1400 cycles
   always @(posedge clk) if (++cycles == 20000) begin
      failCount++;
      finalReport();
   end
   // ****************************************
   // Tasks
   // ****************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         failCount++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= {1'b1, 1'b1, w, 4'hf, a, d};
      // Ends on ack; if ack never comes, only the bench timeout ends this wait
      do @(posedge clk); while (rsp.ack !== 1'b1);
      rd = rsp.dat;
      req <= '0;
   endtask : wb
   task automatic checkAll();
      wb(0, STATUS_OFFSET, 0); chk(rd, {24'h0, va[0], 3'h0, fl[3:0]});
      wb(0, ADDRESS_OFFSET, 0); chk(rd, eA);
      wb(0, PC_OFFSET, 0); chk(rd, ePc);
      chk(sPc, ePc);
      chk(sp, eSp);
      chk({28'h0, flags}, 32'(fl));
   endtask : checkAll
   task automatic fire(input fault_kind_t k, input logic mp, input logic x1);
      logic hit;
      @(posedge clk);
      kind <= k; mpu <= mp; execNever <= x1; val <= rnd();
      @(posedge clk);
      kind <= FAULT_NONE;
      hit = k != FAULT_NONE && (mp || k == FAULT_INSTR && x1);
      repeat (2) @(posedge clk);
      // Entry pulse stands in the cycle after the report is taken
      chk({30'h0, hEntry, cSave}, {30'h0, hit, hit && k != FAULT_UNSTACK});
      if (hit) eSp = val ^ 32'h0000ff00;
      if (k == FAULT_UNSTACK && mp) fl |= 8;
      if (k == FAULT_DATA && mp) begin
         fl |= 2; va = 1; eA = val; ePc = ~val;
      end
      if (k == FAULT_INSTR && (mp || x1)) begin
         fl |= 1; ePc = ~val;
      end
   endtask : fire
   task automatic finalReport();
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finalReport
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      checkAll();
      wb(0, CONTROL_OFFSET, 0); chk(rd, CONTROL_RESET);
      wb(0, 8'h14, 0); chk(rd, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 80; i++) begin
         fire(fault_kind_t'(1 + rnd() % 3), rnd() % 4 != 0, rnd() & 1);
         wb(1, ADDRESS_OFFSET, rnd());
         if (i % 3 == 0) begin
            // Reserved bit 2 is written back as zero
            m = rnd() & 32'h8b;
            wb(1, STATUS_OFFSET, m);
            fl &= ~m[3:0];
            if (m[7]) va = 0;
         end
         checkAll();
      end
      $display("random fault test done");
      // Data fault and a clear of its flag land on the same edge: the set must win
      fork
         fire(FAULT_DATA, 1'b1, 1'b0);
         begin
            @(posedge clk);
            wb(1, STATUS_OFFSET, 32'h2);
         end
      join
      checkAll();
      $display("set over clear test done");
      @(posedge clk); rst <= 1;
      repeat (3) @(posedge clk); rst <= 0;
      fl = 0; va = 0; eA = 0; ePc = 0; eSp = 0;
      checkAll();
      $display("second reset test done");
      finalReport();
   end
endmodule : test_mem_mgmt_fault_status_low
